// ==== spi_port_pkg.sv ====
`default_nettype none
package spi_port_pkg;
    // register byte addresses
    localparam int          ADDR_W           = 5;
    localparam logic [4:0]  ADDR_CONTROL_ONE = 5'h00;
    localparam logic [4:0]  ADDR_STATUS      = 5'h04;
    localparam logic [4:0]  ADDR_BUFFER      = 5'h08;
    localparam logic [4:0]  ADDR_PIN_OPTION  = 5'h0C;
    localparam logic [4:0]  ADDR_EVENT       = 5'h10;
    // serial_port_control_one fields
    localparam int          WRITE_COLLISION_FLAG_BIT         = 7;
    localparam int          OVF_BIT          = 6;
    localparam int          EN_BIT           = 5;
    localparam int          CKP_BIT          = 4;
    localparam int          MODE_LSB         = 0;
    // port_status_register fields
    localparam int          SMP_BIT          = 7;
    localparam int          CKE_BIT          = 6;
    localparam int          BF_BIT           = 0;
    // pin option and event fields
    localparam int          OD_BIT           = 7;
    localparam int          SDO_OFF_BIT      = 5;
    localparam int          IRQ_BIT          = 0;
    // reset values
    localparam logic [7:0]  CONTROL_RESET    = 8'h00;
    localparam logic [7:0]  STATUS_RESET     = 8'h00;
    localparam logic [7:0]  PIN_RESET        = 8'h00;
    localparam logic [7:0]  BUFFER_RESET     = 8'h00;
    // port_mode_field encodings
    localparam logic [3:0]  MODE_DIV4        = 4'h0;
    localparam logic [3:0]  MODE_DIV16       = 4'h1;
    localparam logic [3:0]  MODE_DIV64       = 4'h2;
    localparam logic [3:0]  MODE_TIMER       = 4'h3;
    localparam logic [3:0]  MODE_SLAVE_SS    = 4'h4;
    localparam logic [3:0]  MODE_SLAVE_NOSS  = 4'h5;
    // bit clock dividers, in system clocks per bit
    localparam int          DIV4             = 4;
    localparam int          DIV16            = 16;
    localparam int          DIV64            = 64;
    localparam logic [5:0]  HALF_DIV4        = 6'(DIV4 / 2);
    localparam logic [5:0]  HALF_DIV16       = 6'(DIV16 / 2);
    localparam logic [5:0]  HALF_DIV64       = 6'(DIV64 / 2);
    // serial clock edges per byte
    localparam logic [4:0]  EDGES_LAST       = 5'h0F;
    localparam logic [4:0]  EDGES_EXTRA      = 5'h10;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;
    typedef enum logic {M_IDLE, M_RUN} master_state_t;
endpackage
`default_nettype wire

// ==== sync_serial_spi_port.sv ====
`default_nettype none
// Summary of operation
// - busy buffer write dropped, collision flag set
// - slave byte into full buffer sets overflow
// - master mode never sets overflow
// - enable bit hands pins to port
// - polarity bit sets serial clock idle level
// - modes 0101/0100 slave without/with select
// - master rates: div 4, 16, 64, timer/2
// - msb first; full byte sets full, interrupt
// - receive double-buffered behind shift register
// - buffer read clears buffer-full flag
// - shift register reachable only via buffer
// - master buffer write starts exchange immediately
// - data-out disabled master keeps receiving
// - slave shifts on external clock edges
// - slave runs in sleep, byte wakes
// - open-drain option: drive low only
// - shift on one edge, latch other
// - edge select set: data valid first
// - pin directions follow mode
// - sample bit: end or middle, master only
// - edge select picks output transition
// - high select tri-states, clears bit count
module sync_serial_spi_port #(
    parameter int BYTE_W = 8
) (
    // clock and reset
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // axi4-lite write
    input  wire logic                          awvalid,
    output logic                               awready,
    input  wire logic [spi_port_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                          wvalid,
    output logic                               wready,
    input  wire logic [31:0]                   wdata,
    input  wire logic [3:0]                    wstrb,
    output logic                               bvalid,
    input  wire logic                          bready,
    output logic [1:0]                         bresp,
    // axi4-lite read
    input  wire logic                          arvalid,
    output logic                               arready,
    input  wire logic [spi_port_pkg::ADDR_W-1:0] araddr,
    output logic                               rvalid,
    input  wire logic                          rready,
    output logic [31:0]                        rdata,
    output logic [1:0]                         rresp,
    // serial pins
    input  wire logic                          sck_in,
    output logic                               sck_out,
    output logic                               sck_oe,
    input  wire logic                          sdi_in,
    output logic                               sdo_out,
    output logic                               sdo_oe,
    input  wire logic                          ss_n_in,
    // system side
    input  wire logic                          timer_two_tick,
    input  wire logic                          sleep_in,
    output logic                               wake_pulse,
    output logic                               port_owns_pins,
    output logic                               ss_pin_owned,
    output logic                               port_interrupt_flag
);
    import spi_port_pkg::*;

    if (BYTE_W != 8) begin : g_bad_width
        $error("BYTE_W must be 8");
    end

    // control and status
    logic              write_collision_flag_reg, receive_overflow_flag_reg;
    logic              port_enable_bit_reg, clock_polarity_bit_reg;
    logic [3:0]        port_mode_field_reg;
    logic              input_sample_phase_reg, cke_reg, buffer_full_flag_reg;
    logic              open_drain_select_reg, sdo_off_reg, irq_reg;
    logic [BYTE_W-1:0] buf_reg, tx_sr_reg, rx_sr_reg;
    logic              out_bit_reg, sck_reg, sck_prev_reg, wake_reg;
    logic [3:0]        bit_cnt_reg;
    logic [4:0]        edge_reg;
    logic [5:0]        div_reg;
    master_state_t     mst_reg;
    logic              bvalid_reg, rvalid_reg;
    logic [1:0]        bresp_reg, rresp_reg;
    logic [31:0]       rdata_reg;

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return a == ADDR_CONTROL_ONE || a == ADDR_STATUS || a == ADDR_BUFFER
            || a == ADDR_PIN_OPTION || a == ADDR_EVENT;
    endfunction

    // mode decode
    wire logic is_master = port_mode_field_reg[3:2] == 2'b00;
    wire logic ss_ctrl   = port_mode_field_reg == MODE_SLAVE_SS;
    wire logic is_slave  = ss_ctrl || port_mode_field_reg == MODE_SLAVE_NOSS;
    wire logic en        = port_enable_bit_reg;
    wire logic ss_hold   = en && ss_ctrl && ss_n_in;
    wire logic slave_run = en && is_slave && !ss_hold;
    wire logic cke       = cke_reg;
    wire logic input_sample_phase       = input_sample_phase_reg && is_master;
    wire logic m_run     = mst_reg == M_RUN;
    wire logic busy      = m_run || (slave_run && bit_cnt_reg != 4'h0);

    // bus write decode
    wire logic wr_fire = awvalid && wvalid && !bvalid_reg;
    wire logic wr_lane = wr_fire && wstrb[0];
    wire logic wr_ctl  = wr_lane && awaddr == ADDR_CONTROL_ONE;
    wire logic wr_stat = wr_lane && awaddr == ADDR_STATUS;
    wire logic wr_buf  = wr_lane && awaddr == ADDR_BUFFER;
    wire logic wr_pin  = wr_lane && awaddr == ADDR_PIN_OPTION;
    wire logic wr_evt  = wr_lane && awaddr == ADDR_EVENT;
    wire logic wr_ok   = wr_buf && !busy;
    wire logic start   = wr_ok && en && is_master;
    wire logic rd_fire = arvalid && !rvalid_reg;
    wire logic rd_buf  = rd_fire && araddr == ADDR_BUFFER;

    // master bit clock: one tick per serial clock half period
    wire logic [5:0] half_cnt =
        port_mode_field_reg == MODE_DIV4  ? HALF_DIV4  :
        port_mode_field_reg == MODE_DIV16 ? HALF_DIV16 : HALF_DIV64;
    wire logic timer_mode = port_mode_field_reg == MODE_TIMER;
    wire logic m_tick = m_run && (timer_mode ? timer_two_tick
                                             : div_reg == half_cnt - 6'h01);
    wire logic pend_extra = !cke && input_sample_phase;
    wire logic m_toggle   = m_tick && edge_reg <= EDGES_LAST;
    wire logic m_shift    = m_toggle && edge_reg[0] == cke;
    wire logic m_sample   = m_tick && edge_reg[0] == !(cke ^ input_sample_phase)
                            && !(edge_reg == 5'h00 && !cke);
    wire logic m_end      = m_tick && edge_reg == (pend_extra ? EDGES_EXTRA : EDGES_LAST);

    // slave edges from the external clock
    wire logic s_lead  = slave_run && sck_prev_reg == clock_polarity_bit_reg
                         && sck_in != clock_polarity_bit_reg;
    wire logic s_trail = slave_run && sck_prev_reg != clock_polarity_bit_reg
                         && sck_in == clock_polarity_bit_reg;
    wire logic s_shift  = cke ? s_trail : s_lead;
    wire logic s_sample = cke ? s_lead : s_trail;

    wire logic do_shift  = m_shift || s_shift;
    wire logic do_sample = m_sample || s_sample;
    wire logic [BYTE_W-1:0] rx_next = {rx_sr_reg[BYTE_W-2:0], sdi_in};
    wire logic byte_done = do_sample && bit_cnt_reg == 4'(BYTE_W - 1);
    wire logic ovf_set   = byte_done && is_slave && buffer_full_flag_reg;
    wire logic load_rx   = byte_done && !ovf_set;

    // flag next values: hardware set wins over software clear
    wire logic write_collision_flag_next = (wr_ctl ? wdata[WRITE_COLLISION_FLAG_BIT] : write_collision_flag_reg)
                           || (wr_buf && busy);
    wire logic ovf_next  = (wr_ctl ? wdata[OVF_BIT] : receive_overflow_flag_reg)
                           || ovf_set;
    wire logic bf_next   = load_rx || (buffer_full_flag_reg && !rd_buf);
    wire logic irq_next  = byte_done || (irq_reg && !(wr_evt && wdata[IRQ_BIT]));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            write_collision_flag_reg  <= CONTROL_RESET[WRITE_COLLISION_FLAG_BIT];
            receive_overflow_flag_reg <= CONTROL_RESET[OVF_BIT];
            port_enable_bit_reg       <= CONTROL_RESET[EN_BIT];
            clock_polarity_bit_reg    <= CONTROL_RESET[CKP_BIT];
            port_mode_field_reg       <= CONTROL_RESET[MODE_LSB+:4];
            input_sample_phase_reg    <= STATUS_RESET[SMP_BIT];
            cke_reg                   <= STATUS_RESET[CKE_BIT];
            buffer_full_flag_reg      <= STATUS_RESET[BF_BIT];
            open_drain_select_reg     <= PIN_RESET[OD_BIT];
            sdo_off_reg               <= PIN_RESET[SDO_OFF_BIT];
            irq_reg                   <= 1'b0;
        end else begin
            write_collision_flag_reg  <= write_collision_flag_next;
            receive_overflow_flag_reg <= ovf_next;
            buffer_full_flag_reg      <= bf_next;
            irq_reg                   <= irq_next;
            if (wr_ctl) begin
                port_enable_bit_reg    <= wdata[EN_BIT];
                clock_polarity_bit_reg <= wdata[CKP_BIT];
                port_mode_field_reg    <= wdata[MODE_LSB+:4];
            end
            if (wr_stat) begin
                input_sample_phase_reg <= wdata[SMP_BIT];
                cke_reg                <= wdata[CKE_BIT];
            end
            if (wr_pin) begin
                open_drain_select_reg <= wdata[OD_BIT];
                sdo_off_reg           <= wdata[SDO_OFF_BIT];
            end
        end
    end

    // buffer: a write fills both buffer and shift register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            buf_reg     <= BUFFER_RESET;
            tx_sr_reg   <= BUFFER_RESET;
            out_bit_reg <= 1'b0;
        end else begin
            if (load_rx) begin
                buf_reg <= rx_next;
            end else if (wr_ok) begin
                buf_reg <= wdata[BYTE_W-1:0];
            end
            if (wr_ok) begin
                out_bit_reg <= wdata[BYTE_W-1];
                tx_sr_reg   <= cke ? {wdata[BYTE_W-2:0], 1'b0} : wdata[BYTE_W-1:0];
            end else if (do_shift) begin
                out_bit_reg <= tx_sr_reg[BYTE_W-1];
                tx_sr_reg   <= {tx_sr_reg[BYTE_W-2:0], 1'b0};
            end
        end
    end

    // receive shifter and bit counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_sr_reg   <= BUFFER_RESET;
            bit_cnt_reg <= 4'h0;
        end else if (!en || ss_hold) begin
            bit_cnt_reg <= 4'h0;
        end else if (do_sample) begin
            rx_sr_reg   <= rx_next;
            bit_cnt_reg <= byte_done ? 4'h0 : bit_cnt_reg + 4'h1;
        end
    end

    // master clock generator
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mst_reg  <= M_IDLE;
            edge_reg <= 5'h00;
            div_reg  <= 6'h00;
            sck_reg  <= 1'b0;
        end else begin
            case (mst_reg)
                M_IDLE: begin
                    sck_reg  <= clock_polarity_bit_reg;
                    edge_reg <= 5'h00;
                    div_reg  <= 6'h00;
                    if (start) begin
                        mst_reg <= M_RUN;
                    end
                end
                M_RUN: begin
                    div_reg <= (m_tick || timer_mode) ? 6'h00 : div_reg + 6'h01;
                    if (!en || !is_master || m_end) begin
                        mst_reg <= M_IDLE;
                        sck_reg <= clock_polarity_bit_reg;
                    end else if (m_tick) begin
                        edge_reg <= edge_reg + 5'h01;
                        if (m_toggle) begin
                            sck_reg <= !sck_reg;
                        end
                    end
                end
                default: mst_reg <= M_IDLE;
            endcase
        end
    end

    // slave edge history and wake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sck_prev_reg <= 1'b0;
            wake_reg     <= 1'b0;
        end else begin
            sck_prev_reg <= slave_run ? sck_in : clock_polarity_bit_reg;
            wake_reg     <= byte_done && sleep_in;
        end
    end

    // pins; open drain only ever drives low
    wire logic od        = open_drain_select_reg;
    wire logic sdo_drive = en && (is_master || slave_run) && !sdo_off_reg;
    assign sck_out        = od ? 1'b0 : sck_reg;
    assign sck_oe         = en && is_master && (!od || !sck_reg);
    assign sdo_out        = od ? 1'b0 : out_bit_reg;
    assign sdo_oe         = sdo_drive && (!od || !out_bit_reg);
    assign port_owns_pins = en;
    assign ss_pin_owned   = en && ss_ctrl;
    assign port_interrupt_flag = irq_reg;
    assign wake_pulse     = wake_reg;

    // register read words
    logic [31:0] ctl_word, stat_word, pin_word, evt_word, rd_word;
    always_comb begin
        ctl_word = 32'h0000_0000;
        ctl_word[WRITE_COLLISION_FLAG_BIT]     = write_collision_flag_reg;
        ctl_word[OVF_BIT]      = receive_overflow_flag_reg;
        ctl_word[EN_BIT]       = port_enable_bit_reg;
        ctl_word[CKP_BIT]      = clock_polarity_bit_reg;
        ctl_word[MODE_LSB+:4]  = port_mode_field_reg;
        stat_word = 32'h0000_0000;
        stat_word[SMP_BIT]     = input_sample_phase_reg;
        stat_word[CKE_BIT]     = cke_reg;
        stat_word[BF_BIT]      = buffer_full_flag_reg;
        pin_word = 32'h0000_0000;
        pin_word[OD_BIT]       = open_drain_select_reg;
        pin_word[SDO_OFF_BIT]  = sdo_off_reg;
        evt_word = 32'h0000_0000;
        evt_word[IRQ_BIT]      = irq_reg;
    end
    assign rd_word = araddr == ADDR_CONTROL_ONE ? ctl_word :
                     araddr == ADDR_STATUS      ? stat_word :
                     araddr == ADDR_BUFFER      ? {24'h000000, buf_reg} :
                     araddr == ADDR_PIN_OPTION  ? pin_word :
                     araddr == ADDR_EVENT       ? evt_word : 32'h0000_0000;

    // bus responses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg  <= RESP_OKAY;
            rdata_reg  <= 32'h0000_0000;
        end else begin
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= mapped(awaddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid_reg <= 1'b0;
            end
            if (rd_fire) begin
                rvalid_reg <= 1'b1;
                rresp_reg  <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
                rdata_reg  <= rd_word;
            end else if (rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end
    assign awready = wr_fire;
    assign wready  = wr_fire;
    assign bvalid  = bvalid_reg;
    assign bresp   = bresp_reg;
    assign arready = rd_fire;
    assign rvalid  = rvalid_reg;
    assign rresp   = rresp_reg;
    assign rdata   = rdata_reg;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // shifter may only move by its own shift, never take the refused byte
    chk_collision_drop: assert property (wr_buf && busy |=> write_collision_flag_reg
        && tx_sr_reg == ($past(do_shift) ? {$past(tx_sr_reg[BYTE_W-2:0]), 1'b0} : $past(tx_sr_reg)))
        else $error("collision not flagged");
    chk_overflow_keep: assert property (ovf_set |=> receive_overflow_flag_reg
        && buf_reg == $past(buf_reg)) else $error("overflow handling wrong");
    chk_master_no_ovf: assert property (byte_done && is_master && !receive_overflow_flag_reg
        && !wr_ctl |=> !receive_overflow_flag_reg) else $error("overflow in master");
    chk_pins_released: assert property (!en |-> !sck_oe && !sdo_oe && !port_owns_pins)
        else $error("pins held while disabled");
    chk_idle_level: assert property (mst_reg == M_IDLE ##1 mst_reg == M_IDLE
        |-> sck_reg == $past(clock_polarity_bit_reg)) else $error("idle clock level wrong");
    chk_byte_load: assert property (load_rx |=> buffer_full_flag_reg && irq_reg
        && buf_reg == $past(rx_next)) else $error("byte completion wrong");
    chk_read_clears: assert property (rd_buf && !load_rx |=> !buffer_full_flag_reg)
        else $error("read left buffer full");
    chk_master_start: assert property (start |=> m_run ##0 edge_reg == 5'h00)
        else $error("master did not start");
    chk_select_reset: assert property (ss_hold |-> !sdo_oe ##1 bit_cnt_reg == 4'h0)
        else $error("select high did not reset");
    chk_open_drain: assert property (open_drain_select_reg |-> !sdo_out && !sck_out)
        else $error("open drain drove high");
    chk_div4_tick: assert property (m_run && en && port_mode_field_reg == MODE_DIV4
        && !m_tick && !$changed(port_mode_field_reg) |=> m_tick || !m_run)
        else $error("divide by four rate wrong");

    cov_master_byte: cover property (byte_done && is_master);
    cov_slave_byte:  cover property (byte_done && is_slave);
    cov_overflow:    cover property (ovf_set);
    cov_collision:   cover property (wr_buf && busy);
endmodule // sync_serial_spi_port
`default_nettype wire

// ==== spi_far_end.sv ====
`default_nettype none
module spi_far_end (
    // control
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       drive_clk,
    input  wire logic       clock_polarity_bit,
    input  wire logic [7:0] tx_byte,
    input  wire logic       load,
    // serial lines
    input  wire logic       sck_line,
    input  wire logic       sdo_line,
    output logic            sck_drv,
    output logic            sdi_drv,
    output logic [7:0]      rx_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sr_reg;
    logic [7:0] cnt_reg;
    logic       run_reg;
    logic       prev_reg;
    wire logic  edge_seen = sck_line != prev_reg;
    // idle level held between frames; a released line is pulled up
    assign sck_drv = drive_clk ? (clock_polarity_bit ^ (run_reg & cnt_reg[3])) : 1'b1;
    assign sdi_drv = sr_reg[7];
    always_ff @(posedge aclk) begin
        prev_reg <= sck_line;
        cnt_reg  <= load ? 8'h00 : cnt_reg + 8'h01;
        if (!aresetn) begin
            run_reg <= 1'b0;
            sr_reg  <= 8'h00;
        end else if (load) begin
            sr_reg  <= tx_byte;
            run_reg <= drive_clk;
        end else begin
            if (run_reg && cnt_reg == 8'h7F) begin
                run_reg <= 1'b0;
            end
            // leading edge latches, trailing edge shifts; fresh bits keep a stale line moving
            if (edge_seen && sck_line != clock_polarity_bit) begin
                rx_byte <= {rx_byte[6:0], sdo_line};
            end
            if (edge_seen && sck_line == clock_polarity_bit) begin
                sr_reg <= {sr_reg[6:0], ~sr_reg[7]};
            end
        end
    end
endmodule // spi_far_end
`default_nettype wire

// ==== sync_serial_spi_port_tb.sv ====
`default_nettype none
module sync_serial_spi_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import spi_port_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ss_n_in, drive_clk, load;
    logic        far_ckp, sleep_in, timer_two_tick;
    logic [4:0]  awaddr, araddr;
    logic [31:0] wdata;
    logic [7:0]  far_tx, got;
    logic [1:0]  rsp;
    wire         awready, wready, bvalid, arready, rvalid, sck_out, sck_oe, sdo_out, sdo_oe, far_sck, far_sdi;
    wire         wake_pulse, port_owns_pins, ss_pin_owned, port_interrupt_flag;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    wire [7:0]   far_rx;
    wire         sck_line = sck_oe ? sck_out : far_sck;
    wire         sdo_line = sdo_oe ? sdo_out : 1'b1;
    int          error_cnt, checks, cycles;
    sync_serial_spi_port #(.BYTE_W(8)) dut (
        .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid,
        .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .sck_in(sck_line),
        .sck_out, .sck_oe, .sdi_in(far_sdi), .sdo_out, .sdo_oe, .ss_n_in, .timer_two_tick,
        .sleep_in, .wake_pulse, .port_owns_pins, .ss_pin_owned, .port_interrupt_flag);
    spi_far_end far (.aclk, .aresetn, .drive_clk, .clock_polarity_bit(far_ckp), .tx_byte(far_tx), .load, .sck_line,
        .sdo_line, .sck_drv(far_sck), .sdi_drv(far_sdi), .rx_byte(far_rx));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles++;
        timer_two_tick <= cycles % 3 == 0;
        if (cycles == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // bready and rready stay high for the whole run
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        @(posedge aclk iff (awready === 1'b1));
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        @(posedge aclk iff (bvalid === 1'b1));
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        @(posedge aclk iff (arready === 1'b1));
        arvalid <= 1'b0;
        @(posedge aclk iff (rvalid === 1'b1));
        got = rdata[7:0];
        rsp = rresp;
    endtask
    task automatic frame(input logic [7:0] b);
        @(posedge aclk);
        far_tx <= b;
        load   <= 1'b1;
        @(posedge aclk);
        load   <= 1'b0;
    endtask
    task automatic byte_done();
        repeat (400) if (port_interrupt_flag !== 1'b1) @(negedge aclk);
        chk({7'h00, port_interrupt_flag}, 8'h01);
        wr(ADDR_EVENT, 8'h01);
    endtask
    task automatic test_master();
        rd(ADDR_CONTROL_ONE);
        chk(got, CONTROL_RESET);
        rd(5'h14);
        chk({6'h00, rsp}, {6'h00, RESP_SLVERR});
        wr(ADDR_CONTROL_ONE, 8'h30);
        @(negedge aclk);
        chk({sck_oe, sck_out, port_owns_pins, 5'h00}, 8'hE0);
        wr(ADDR_CONTROL_ONE, 8'h20);
        wr(ADDR_STATUS, 8'h40);
        chk({sck_oe, sck_out, 6'h00}, 8'h80);
        frame(8'hA5);
        wr(ADDR_BUFFER, 8'h3C);
        wr(ADDR_BUFFER, 8'hFF);
        byte_done();
        chk(far_rx, 8'h3C);
        rd(ADDR_STATUS);
        chk(got, 8'h41);
        rd(ADDR_BUFFER);
        chk(got, 8'hA5);
        rd(ADDR_STATUS);
        chk(got, 8'h40);
        rd(ADDR_CONTROL_ONE);
        chk(got, 8'hA0);
    endtask
    task automatic test_slave();
        drive_clk <= 1'b1;
        wr(ADDR_CONTROL_ONE, 8'h00);
        wr(ADDR_CONTROL_ONE, 8'h24);
        chk({ss_pin_owned, sck_oe, 6'h00}, 8'h80);
        frame(8'h81);
        byte_done();
        frame(8'h7E);
        byte_done();
        rd(ADDR_CONTROL_ONE);
        chk(got, 8'h64);
        rd(ADDR_BUFFER);
        chk(got, 8'h81);
        ss_n_in <= 1'b1;
        frame(8'h55);
        repeat (200) @(posedge aclk);
        chk({sdo_oe, port_interrupt_flag, 6'h00}, 8'h00);
    endtask
    task automatic test_timer_od();
        wr(ADDR_CONTROL_ONE, 8'h00);
        wr(ADDR_PIN_OPTION, 8'h80);
        wr(ADDR_STATUS, 8'h00);
        drive_clk <= 1'b0;
        far_ckp   <= 1'b1;
        sleep_in  <= 1'b1;
        wr(ADDR_CONTROL_ONE, 8'h33);
        @(negedge aclk);
        chk({sck_oe, sck_out, sdo_out, 5'h00}, 8'h00);
        frame(8'h96);
        wr(ADDR_BUFFER, 8'h5A);
        repeat (400) if (port_interrupt_flag !== 1'b1) @(negedge aclk);
        chk({7'h00, wake_pulse}, 8'h01);
        byte_done();
        chk(far_rx, 8'h5A);
        rd(ADDR_BUFFER);
        chk(got, 8'h96);
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        aresetn <= 1'b0;
        {awvalid, wvalid, arvalid, load, drive_clk, far_ckp, sleep_in} <= 7'h00;
        {bready, rready, ss_n_in} <= 3'h6;
        {awaddr, araddr, wdata, far_tx} <= '0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        test_master();
        test_slave();
        test_timer_od();
        conclude();
    end
endmodule // sync_serial_spi_port_tb
`default_nettype wire
